// >>> rtl/crtc_counter.sv
// Wrapping time counter with synchronous load
`timescale 1ns/1ps
`default_nettype none
module crtc_counter #(
    parameter int WIDTH = 6,
    parameter int MODULUS = 60
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic step,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    output logic [WIDTH-1:0] value,
    output logic wrap
);

    // ---------------------------------------------------------------
    // Parameter check
    // ---------------------------------------------------------------
    if (MODULUS < 2 || MODULUS > (1 << WIDTH)) begin : g_bad_modulus
        $error("crtc_counter: modulus does not fit the width");
    end

    localparam logic [WIDTH-1:0] LAST = WIDTH'(MODULUS - 1);

    logic [WIDTH-1:0] countQ, countD;

    // Out of range loads wrap on the next step
    always_comb begin
        wrap = step && !load && (countQ >= LAST);
        countD = countQ;
        if (load) begin
            countD = loadValue;
        end else if (step) begin
            countD = wrap ? '0 : WIDTH'(countQ + 1'b1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            countQ <= '0;
        end else if (ce) begin
            countQ <= countD;
        end
    end

    assign value = countQ;

endmodule // crtc_counter
`default_nettype wire

// >>> rtl/crtc_pkg.sv
// Constants of the calendar clock with alarms and stopwatch
package crtc_pkg;

    // ---------------------------------------------------------------
    // Clocks and rates
    // ---------------------------------------------------------------
    localparam int CORE_CLK_HZ = 40000000;
    localparam int CRYSTAL_HZ = 32768;
    localparam int TICK_HZ = 1;
    localparam int PRESCALE_DIV = CRYSTAL_HZ / TICK_HZ;

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_TIME = 8'h00;
    localparam logic [7:0] OFF_ALARM_TOD = 8'h04;
    localparam logic [7:0] OFF_ALARM_DAY = 8'h08;
    localparam logic [7:0] OFF_STOPWATCH = 8'h0C;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h10;
    localparam logic [7:0] OFF_INT_STATUS = 8'h14;

    // ---------------------------------------------------------------
    // Time word layout
    // ---------------------------------------------------------------
    localparam int SEC_W = 6;
    localparam int MIN_W = 6;
    localparam int HOUR_W = 5;
    localparam int DAY_W = 15;
    localparam int SEC_LSB = 0;
    localparam int MIN_LSB = 6;
    localparam int HOUR_LSB = 12;
    localparam int DAY_LSB = 17;
    localparam int TOD_BITS = 17;
    localparam int SEC_MOD = 60;
    localparam int MIN_MOD = 60;
    localparam int HOUR_MOD = 24;
    localparam int DAY_MOD = 32768;
    localparam int SW_W = 32;

    // ---------------------------------------------------------------
    // Interrupt bits
    // ---------------------------------------------------------------
    localparam int INT_SEC = 0;
    localparam int INT_MIN = 1;
    localparam int INT_HOUR = 2;
    localparam int INT_DAY = 3;
    localparam int INT_ALM_TOD = 4;
    localparam int INT_ALM_DAY = 5;
    localparam int INT_SW = 6;
    localparam int INT_COUNT = 7;
    localparam int SW_RUN_BIT = 7;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [6:0] RST_INT = 7'h00;

    typedef enum logic [0:0] {
        CRTC_SW_IDLE = 1'b0,
        CRTC_SW_RUN = 1'b1
    } crtc_sw_state_t;

endpackage

// >>> rtl/crtc_top.sv
// Calendar clock: prescaler, time counters, alarms, stopwatch, interrupts
`timescale 1ns/1ps
`default_nettype none
module crtc_top #(
    parameter int PRESCALE_DIV = crtc_pkg::PRESCALE_DIV
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic crystalInPin,
    output logic crystalOutPin,
    input wire logic [crtc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [crtc_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [crtc_pkg::DATA_W-1:0] regRdData,
    output logic calibrationTickOut,
    output logic irq
);

    // ---------------------------------------------------------------
    // Parameter check
    // ---------------------------------------------------------------
    localparam int PW = (PRESCALE_DIV > 2) ? $clog2(PRESCALE_DIV) : 1;
    localparam logic [PW-1:0] PRESC_LAST = PW'(PRESCALE_DIV - 1);
    localparam logic [PW-1:0] PRESC_HALF = PW'(PRESCALE_DIV / 2);

    if (PRESCALE_DIV < 2 || (PRESCALE_DIV & (PRESCALE_DIV - 1)) != 0)
    begin : g_bad_div
        $error("crtc_top: prescale divider must be a power of two");
    end

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    logic timeWrite, todWrite, dayWrite, swWrite, enWrite, stWrite;

    always_comb begin
        timeWrite = ce && regWrite && (regAddr == crtc_pkg::OFF_TIME);
        todWrite = ce && regWrite && (regAddr == crtc_pkg::OFF_ALARM_TOD);
        dayWrite = ce && regWrite && (regAddr == crtc_pkg::OFF_ALARM_DAY);
        swWrite = ce && regWrite && (regAddr == crtc_pkg::OFF_STOPWATCH);
        enWrite = ce && regWrite && (regAddr == crtc_pkg::OFF_INT_ENABLE);
        stWrite = ce && regWrite && (regAddr == crtc_pkg::OFF_INT_STATUS);
    end

    // ---------------------------------------------------------------
    // Prescaler
    // ---------------------------------------------------------------
    logic [PW-1:0] prescQ, prescD;
    logic crystalPrevQ, crystalPrevD;
    logic crystalOutQ, crystalOutD;
    logic calQ, calD;
    logic tick;

    // No sleep input gates this path; only ce freezes it
    always_comb begin
        crystalPrevD = crystalInPin;
        crystalOutD = ~crystalInPin;
        calD = prescQ[PW-1];
        tick = ce && crystalInPin && !crystalPrevQ
            && (prescQ == PRESC_LAST);
        prescD = prescQ;
        if (timeWrite) begin
            prescD = '0;
        end else if (crystalInPin && !crystalPrevQ) begin
            prescD = PW'(prescQ + 1'b1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            prescQ <= '0;
            crystalPrevQ <= 1'b0;
            crystalOutQ <= 1'b1;
            calQ <= 1'b0;
        end else if (ce) begin
            prescQ <= prescD;
            crystalPrevQ <= crystalPrevD;
            crystalOutQ <= crystalOutD;
            calQ <= calD;
        end
    end

    assign crystalOutPin = crystalOutQ;
    assign calibrationTickOut = calQ;

    // ---------------------------------------------------------------
    // Time counters
    // ---------------------------------------------------------------
    logic [crtc_pkg::SEC_W-1:0] secValue;
    logic [crtc_pkg::MIN_W-1:0] minValue;
    logic [crtc_pkg::HOUR_W-1:0] hourValue;
    logic [crtc_pkg::DAY_W-1:0] dayValue;
    logic secWrap, minWrap, hourWrap;
    logic [31:0] timeWord;

    crtc_counter #(.WIDTH(crtc_pkg::SEC_W), .MODULUS(crtc_pkg::SEC_MOD))
    u_sec (
        .core_clk(core_clk), .srst(srst), .ce(ce),
        .step(tick),
        .load(timeWrite),
        .loadValue(regWrData[crtc_pkg::SEC_LSB +: crtc_pkg::SEC_W]),
        .value(secValue), .wrap(secWrap)
    );

    crtc_counter #(.WIDTH(crtc_pkg::MIN_W), .MODULUS(crtc_pkg::MIN_MOD))
    u_min (
        .core_clk(core_clk), .srst(srst), .ce(ce),
        .step(secWrap),
        .load(timeWrite),
        .loadValue(regWrData[crtc_pkg::MIN_LSB +: crtc_pkg::MIN_W]),
        .value(minValue), .wrap(minWrap)
    );

    crtc_counter #(.WIDTH(crtc_pkg::HOUR_W), .MODULUS(crtc_pkg::HOUR_MOD))
    u_hour (
        .core_clk(core_clk), .srst(srst), .ce(ce),
        .step(minWrap),
        .load(timeWrite),
        .loadValue(regWrData[crtc_pkg::HOUR_LSB +: crtc_pkg::HOUR_W]),
        .value(hourValue), .wrap(hourWrap)
    );

    crtc_counter #(.WIDTH(crtc_pkg::DAY_W), .MODULUS(crtc_pkg::DAY_MOD))
    u_day (
        .core_clk(core_clk), .srst(srst), .ce(ce),
        .step(hourWrap),
        .load(timeWrite),
        .loadValue(regWrData[crtc_pkg::DAY_LSB +: crtc_pkg::DAY_W]),
        .value(dayValue), .wrap()
    );

    assign timeWord = {dayValue, hourValue, minValue, secValue};

    // ---------------------------------------------------------------
    // Alarms, stopwatch and control registers
    // ---------------------------------------------------------------
    logic [31:0] almTodQ, almTodD, almDayQ, almDayD;
    logic [crtc_pkg::SW_W-1:0] swQ, swD;
    crtc_pkg::crtc_sw_state_t swStateQ, swStateD;
    logic [crtc_pkg::INT_COUNT-1:0] enableQ, enableD, statusQ, statusD;
    logic [crtc_pkg::INT_COUNT-1:0] events, clearMask;
    logic timeChangedQ, timeChangedD;
    logic todMatch, dayMatch, swUnder;

    always_comb begin
        almTodD = todWrite ? regWrData : almTodQ;
        almDayD = dayWrite ? regWrData : almDayQ;
        enableD = enWrite ? regWrData[crtc_pkg::INT_COUNT-1:0] : enableQ;
        timeChangedD = tick || timeWrite;
        todMatch = timeWord[crtc_pkg::TOD_BITS-1:0]
            == almTodQ[crtc_pkg::TOD_BITS-1:0];
        dayMatch = timeWord == almDayQ;
        swUnder = 1'b0;
        swD = swQ;
        swStateD = swStateQ;
        if (swWrite) begin
            swD = regWrData[crtc_pkg::SW_W-1:0];
            swStateD = crtc_pkg::CRTC_SW_RUN;
        end else begin
            case (swStateQ)
                crtc_pkg::CRTC_SW_RUN: begin
                    if (tick && swQ == '0) begin
                        swUnder = 1'b1;
                        swStateD = crtc_pkg::CRTC_SW_IDLE;
                    end else if (tick) begin
                        swD = crtc_pkg::SW_W'(swQ - 1'b1);
                    end
                end
                crtc_pkg::CRTC_SW_IDLE: begin
                    swStateD = crtc_pkg::CRTC_SW_IDLE;
                end
                default: begin
                    swStateD = crtc_pkg::CRTC_SW_IDLE;
                end
            endcase
        end
        events = '0;
        events[crtc_pkg::INT_SEC] = tick;
        events[crtc_pkg::INT_MIN] = secWrap;
        events[crtc_pkg::INT_HOUR] = minWrap;
        events[crtc_pkg::INT_DAY] = hourWrap;
        events[crtc_pkg::INT_ALM_TOD] = timeChangedQ && todMatch;
        events[crtc_pkg::INT_ALM_DAY] = timeChangedQ && dayMatch;
        events[crtc_pkg::INT_SW] = swUnder;
        clearMask = stWrite ? regWrData[crtc_pkg::INT_COUNT-1:0] : '0;
        statusD = (statusQ & ~clearMask) | events;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            almTodQ <= crtc_pkg::RST_WORD;
            almDayQ <= crtc_pkg::RST_WORD;
            swQ <= '0;
            swStateQ <= crtc_pkg::CRTC_SW_IDLE;
            enableQ <= crtc_pkg::RST_INT;
            statusQ <= crtc_pkg::RST_INT;
            timeChangedQ <= 1'b0;
        end else if (ce) begin
            almTodQ <= almTodD;
            almDayQ <= almDayD;
            swQ <= swD;
            swStateQ <= swStateD;
            enableQ <= enableD;
            statusQ <= statusD;
            timeChangedQ <= timeChangedD;
        end
    end

    assign irq = |(statusQ & enableQ);

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    logic [31:0] rdQ, rdD;

    always_comb begin
        rdD = '0;
        if (regRead) begin
            case (regAddr)
                crtc_pkg::OFF_TIME: rdD = timeWord;
                crtc_pkg::OFF_ALARM_TOD: rdD = almTodQ;
                crtc_pkg::OFF_ALARM_DAY: rdD = almDayQ;
                crtc_pkg::OFF_STOPWATCH: rdD = swQ;
                crtc_pkg::OFF_INT_ENABLE: rdD[6:0] = enableQ;
                crtc_pkg::OFF_INT_STATUS: begin
                    rdD[6:0] = statusQ;
                    rdD[crtc_pkg::SW_RUN_BIT] =
                        (swStateQ == crtc_pkg::CRTC_SW_RUN);
                end
                default: rdD = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdQ <= '0;
        end else if (ce) begin
            rdQ <= rdD;
        end
    end

    assign regRdData = rdQ;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence secLastTick;
        tick && !timeWrite && secValue == 6'h3B;
    endsequence

    sequence swLastTick;
        tick && !swWrite && swStateQ == crtc_pkg::CRTC_SW_RUN && swQ == '0;
    endsequence

    presc_restart_a: assert property (
        tick && !timeWrite |=> prescQ == '0 && secValue != $past(secValue))
        else $error("prescaler did not restart on the second tick");

    sec_carry_a: assert property (
        secLastTick and (minValue != 6'h3B)
        |=> secValue == 6'h00 && minValue == 6'($past(minValue) + 6'h01))
        else $error("seconds wrap did not carry into minutes");

    hour_wrap_a: assert property (
        minWrap && !timeWrite && hourValue == 5'h17 |=> hourValue == 5'h00)
        else $error("hours did not wrap after 24");

    day_step_a: assert property (
        hourWrap && !timeWrite
        |=> dayValue == 15'($past(dayValue) + 15'h0001))
        else $error("day counter did not advance on hours wrap");

    alarm_tod_a: assert property (
        ce && timeChangedQ
        && timeWord[16:0] == almTodQ[16:0] |=> statusQ[4])
        else $error("time of day alarm missed");

    alarm_day_a: assert property (
        ce && timeChangedQ && timeWord == almDayQ |=> statusQ[5])
        else $error("day alarm missed");

    alarm_irq_a: assert property (
        statusQ[4] && enableQ[4] |-> irq)
        else $error("enabled alarm flag without interrupt");

    sw_count_a: assert property (
        tick && !swWrite && swStateQ == crtc_pkg::CRTC_SW_RUN && swQ != '0
        |=> swQ == 32'($past(swQ) - 32'h00000001))
        else $error("stopwatch did not decrement");

    sw_under_a: assert property (
        swLastTick |=> statusQ[6] && swStateQ == crtc_pkg::CRTC_SW_IDLE
        && swQ == '0)
        else $error("stopwatch underflow not flagged");

    tick_flag_a: assert property (
        tick |=> statusQ[0])
        else $error("seconds tick flag not set");

    cal_rise_a: assert property (
        $rose(calibrationTickOut) |-> $past(prescQ) == PRESC_HALF)
        else $error("calibration output rose at wrong prescale phase");

    flag_sticky_a: assert property (
        statusQ[0] && !(stWrite && regWrData[0]) |=> statusQ[0])
        else $error("sticky flag dropped without a clear");

    time_load_a: assert property (
        timeWrite |=> timeWord == $past(regWrData))
        else $error("time write not loaded");

endmodule // crtc_top
`default_nettype wire

// >>> testbench/crtc_crystal_model.sv
// Free-running crystal oscillator seen at the clock input pin
`timescale 1ns/1ps
`default_nettype none
module crtc_crystal_model (
    input wire logic fast,
    output logic xtalLevel
);
    // Edges kept off rising core clock edges; slow mode stretches the period
    initial begin
        xtalLevel = 1'b0;
        #25.0;
        forever begin
            #(fast ? 50.0 : 150.0);
            xtalLevel = ~xtalLevel;
        end
    end
endmodule // crtc_crystal_model
`default_nettype wire

// >>> testbench/crtc_top_tb_top.sv
// Bench for the calendar clock: scoreboard, scenarios and verdict
`timescale 1ns/1ps
`default_nettype none
module crtc_top_tb_top;
    localparam int DIV = 8;
    typedef struct {
        logic chk;
        logic [31:0] mask;
        logic [31:0] exp;
        string name;
    } crtc_note_t;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic fastXtal = 1'b1;
    logic crystalInPin;
    logic crystalOutPin;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h00000000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdData;
    logic calibrationTickOut;
    logic irq;
    logic rdWas = 1'b0;
    logic [31:0] rdv;
    logic [31:0] seed = 32'h7062E5FC;
    int fails = 0;
    int nChecks = 0;
    crtc_note_t notes[$];
    crtc_note_t cur;

    crtc_crystal_model xtal (.fast(fastXtal), .xtalLevel(crystalInPin));

    crtc_top #(.PRESCALE_DIV(DIV)) dut (
        .core_clk(core_clk), .srst(srst), .ce(ce),
        .crystalInPin(crystalInPin), .crystalOutPin(crystalOutPin),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData),
        .calibrationTickOut(calibrationTickOut), .irq(irq)
    );

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] tw(int d, int h, int m, int s);
        return {d[14:0], h[4:0], m[5:0], s[5:0]};
    endfunction

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e,
                      string nm, logic chk);
        crtc_note_t n;
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        n.chk = chk;
        n.mask = m;
        n.exp = e;
        n.name = nm;
        notes.push_back(n);
        @(posedge core_clk);
        rdv = regRdData;
    endtask

    // Clears the second flag and polls until the next tick sets it
    task automatic wait_tick();
        int k;
        wr(crtc_pkg::OFF_INT_STATUS, 32'h00000001);
        for (k = 0; k < 400; k++) begin
            rd(crtc_pkg::OFF_INT_STATUS, '0, '0, "poll", 1'b0);
            if (rdv[0] === 1'b1) break;
        end
        if (k == 400) check("tickWait", 32'h0, 32'h1);
    endtask

    // ---------------------------------------------------------------
    // Read data scoreboard
    // ---------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rdWas && notes.size() > 0) begin
            cur = notes.pop_front();
            if (cur.chk) check(cur.name, regRdData & cur.mask, cur.exp);
        end
        rdWas <= regRead;
    end

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic cal_test();
        int k;
        int rises;
        int tog;
        logic px;
        logic pc;
        rises = 0;
        tog = 0;
        px = crystalInPin;
        pc = calibrationTickOut;
        for (k = 0; k < 400 && tog < 3; k++) begin
            @(posedge core_clk);
            check("xtalOut", {31'h0, crystalOutPin}, {31'h0, ~px});
            if (crystalInPin && !px) rises++;
            if (calibrationTickOut !== pc) begin
                if (tog > 0) begin
                    check("calRises", 32'(rises), 32'(DIV / 2));
                end
                tog++;
                rises = 0;
            end
            pc = calibrationTickOut;
            px = crystalInPin;
        end
        check("calToggles", 32'(tog), 32'h3);
    endtask

    initial begin
        int c;
        logic [31:0] r;
        int dIn[2] = '{5, 32767};
        int dOut[2] = '{6, 0};
        int aDay[2] = '{6, 5};
        logic [31:0] aExp[2] = '{32'h30, 32'h10};
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        check("irqReset", {31'h0, irq}, 32'h0);
        rd(crtc_pkg::OFF_ALARM_TOD, '1, '0, "almTodRst", 1'b1);
        rd(crtc_pkg::OFF_ALARM_DAY, '1, '0, "almDayRst", 1'b1);
        rd(crtc_pkg::OFF_INT_ENABLE, '1, '0, "enRst", 1'b1);
        rd(crtc_pkg::OFF_STOPWATCH, '1, '0, "swRst", 1'b1);
        for (c = 0; c < 4; c++) begin
            r = xs();
            wr(crtc_pkg::OFF_ALARM_TOD, r);
            wr(crtc_pkg::OFF_ALARM_DAY, ~r);
            wr(crtc_pkg::OFF_INT_ENABLE, r);
            wr(8'h18, r);
            rd(crtc_pkg::OFF_ALARM_TOD, 32'h1FFFF, r & 32'h1FFFF,
               "almTod", 1'b1);
            rd(crtc_pkg::OFF_ALARM_DAY, '1, ~r, "almDay", 1'b1);
            rd(crtc_pkg::OFF_INT_ENABLE, 32'h7F, r & 32'h7F,
               "en", 1'b1);
            rd(8'h18, '1, '0, "unmapped", 1'b1);
        end
        $display("test registers done");
        wr(crtc_pkg::OFF_INT_ENABLE, 32'h7F);
        for (c = 0; c < 2; c++) begin
            wr(crtc_pkg::OFF_ALARM_TOD, tw(0, 0, 0, 1));
            wr(crtc_pkg::OFF_ALARM_DAY, tw(aDay[c], 0, 0, 1));
            wr(crtc_pkg::OFF_TIME, tw(dIn[c], 23, 59, 59));
            rd(crtc_pkg::OFF_TIME, '1, tw(dIn[c], 23, 59, 59),
               "timeLd", 1'b1);
            wr(crtc_pkg::OFF_INT_STATUS, 32'h7F);
            wait_tick();
            rd(crtc_pkg::OFF_INT_STATUS, 32'h3F, 32'h0F, "roll", 1'b1);
            rd(crtc_pkg::OFF_TIME, '1, tw(dOut[c], 0, 0, 0),
               "wrap", 1'b1);
            wait_tick();
            rd(crtc_pkg::OFF_INT_STATUS, 32'h30, aExp[c],
               "alarm", 1'b1);
            check("irqOn", {31'h0, irq}, 32'h1);
            wr(crtc_pkg::OFF_INT_ENABLE, 32'h00);
            check("irqMask", {31'h0, irq}, 32'h0);
            wr(crtc_pkg::OFF_INT_ENABLE, 32'h10);
            check("irqSticky", {31'h0, irq}, 32'h1);
            wr(crtc_pkg::OFF_INT_STATUS, 32'h7F);
            check("irqClr", {31'h0, irq}, 32'h0);
            wr(crtc_pkg::OFF_INT_ENABLE, 32'h7F);
        end
        $display("test calendar done");
        fastXtal <= 1'b0;
        wait_tick();
        wr(crtc_pkg::OFF_INT_STATUS, 32'h7F);
        wr(crtc_pkg::OFF_STOPWATCH, 32'h00000002);
        rd(crtc_pkg::OFF_INT_STATUS, 32'hC0, 32'h80, "swRun", 1'b1);
        wait_tick();
        rd(crtc_pkg::OFF_STOPWATCH, '1, 32'h1, "swCnt1", 1'b1);
        wait_tick();
        rd(crtc_pkg::OFF_STOPWATCH, '1, 32'h0, "swCnt0", 1'b1);
        rd(crtc_pkg::OFF_INT_STATUS, 32'hC0, 32'h80, "swWait", 1'b1);
        wait_tick();
        rd(crtc_pkg::OFF_INT_STATUS, 32'hC0, 32'h40, "swUnder", 1'b1);
        $display("test stopwatch done");
        fastXtal <= 1'b1;
        wr(crtc_pkg::OFF_TIME, 32'h00000000);
        // Clock enable low must freeze the whole calendar
        ce <= 1'b0;
        repeat (200) @(posedge core_clk);
        ce <= 1'b1;
        @(posedge core_clk);
        rd(crtc_pkg::OFF_TIME, '1, '0, "ceFreeze", 1'b1);
        cal_test();
        $display("test calibration done");
        repeat (4) @(posedge core_clk);
        stop_test();
    end

    initial begin
        repeat (30000) @(posedge core_clk);
        fails++;
        stop_test();
    end
endmodule // crtc_top_tb_top
`default_nettype wire
